// *** mhsp_pkg.sv ***
// shared constants, types and the checksum function of the modem host serial port
package mhsp_pkg;

   // ==========================================================
   // clock and serial timing
   localparam int CLK_HZ = 100000000;
   localparam int DEF_BAUD = 9600;
   localparam int OVERSAMPLE = 16;
   // clocks per sixteenth of a bit at the factory default rate, rounded down
   localparam logic [15:0] DEF_DIV = 16'(CLK_HZ / (DEF_BAUD * OVERSAMPLE));
   localparam logic [3:0] MID_START = 4'h7;
   localparam logic [3:0] LAST_SUB = 4'hf;
   localparam logic [3:0] DATA_BITS = 4'h8;
   localparam logic [3:0] FRAME_LAST = 4'h9;

   // ==========================================================
   // buffer sizes and flow control levels
   localparam logic [7:0] BUF_DEPTH = 8'h84;   // 132 bytes
   localparam logic [7:0] CTS_OFF_LEVEL = 8'h73;   // 115 bytes
   localparam logic [7:0] CTS_ON_LEVEL = 8'h62;   // 98 bytes
   localparam logic [7:0] PKT_MAX = 8'h40;   // 64 bytes
   localparam int RXQ_DEPTH = 128;
   localparam logic [6:0] RX_CRC_LEN = 7'h02;

   // ==========================================================
   // packet check
   localparam logic [15:0] CRC_INIT = 16'h0000;
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [7:0] HDR_TOKEN = 8'h00;

   // ==========================================================
   // radio byte kinds and reported modes
   localparam logic [1:0] KIND_HDR = 2'h0;
   localparam logic [1:0] KIND_DATA = 2'h1;
   localparam logic [1:0] KIND_CRC = 2'h2;
   localparam logic [1:0] MODE_IDLE = 2'h0;
   localparam logic [1:0] MODE_TX = 2'h1;
   localparam logic [1:0] MODE_RX = 2'h2;

   typedef enum logic [2:0] {
      MHSP_IDLE, MHSP_TX_HDR, MHSP_TX_DATA, MHSP_TX_CRC_HI, MHSP_TX_CRC_LO, MHSP_TX_END, MHSP_RX
   } mhsp_mode_t;

   typedef enum logic [1:0] {RXS_IDLE, RXS_START, RXS_DATA, RXS_STOP} mhsp_rxs_t;

   // one byte step of the 16-bit check, msb first
   function automatic logic [15:0] mhsp_crc16(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] x;
      x = c ^ {d, 8'h00};
      for (int i = 0; i < 8; i++) begin
         x = x[15] ? ((x << 1) ^ CRC_POLY) : (x << 1);
      end
      return x;
   endfunction

endpackage

// *** mhsp_mem.sv ***
// small byte memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module mhsp_mem #(
   parameter int DEPTH = 132,
   parameter int AW = 8
) (
   // clock
   input wire logic i_clk,
   input wire logic i_ce,
   // write port
   input wire logic i_we,
   input wire logic [AW-1:0] i_waddr,
   input wire logic [7:0] i_wdata,
   // read port
   input wire logic [AW-1:0] i_raddr,
   output logic [7:0] o_rdata
);
   logic [7:0] mem [DEPTH];

   // no reset on the array: contents are only read after being written
   always_ff @(posedge i_clk) begin
      if (i_ce) begin
         if (i_we) begin
            mem[i_waddr] <= i_wdata;
         end
         o_rdata <= mem[i_raddr];
      end
   end
endmodule
`default_nettype wire

// *** mhsp_uart_rx.sv ***
// host serial input receiver, 16x oversampled
`timescale 1ns/1ns
`default_nettype none
module mhsp_uart_rx
   import mhsp_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   // serial line and rate
   input wire logic i_line,
   input wire logic [15:0] i_div,
   // received character
   output logic o_valid,
   output logic [7:0] o_data,
   output logic o_frame_err
);
   typedef struct packed {
      logic s1;
      logic s2;
      mhsp_rxs_t st;
      logic [15:0] cnt;
      logic [3:0] sub;
      logic [3:0] nbit;
      logic [7:0] sh;
      logic valid;
      logic ferr;
   } mhsp_rx_t;

   mhsp_rx_t r;
   mhsp_rx_t n;
   logic tick;

   // ==========================================================
   // framing: start low, 8 bits lsb first, stop high
   always_comb begin
      n = r;
      n.valid = 1'b0;
      n.ferr = 1'b0;
      n.s1 = i_line;
      n.s2 = r.s1;   // only s2 is looked at
      tick = (r.cnt >= i_div - 16'h0001);
      n.cnt = tick ? 16'h0000 : r.cnt + 16'h0001;
      if (r.st == RXS_IDLE) begin
         n.cnt = 16'h0000;
         n.sub = 4'h0;
         if (!r.s2) begin
            n.st = RXS_START;
         end
      end else if (tick) begin
         n.sub = r.sub + 4'h1;
         unique case (r.st)
            RXS_START: begin
               // recheck at mid start so a glitch is not taken as a character
               if (r.sub == MID_START) begin
                  n.sub = 4'h0;
                  n.nbit = 4'h0;
                  n.st = r.s2 ? RXS_IDLE : RXS_DATA;
               end
            end
            RXS_DATA: begin
               if (r.sub == LAST_SUB) begin
                  n.sh = {r.s2, r.sh[7:1]};
                  n.nbit = r.nbit + 4'h1;
                  if (r.nbit == DATA_BITS - 4'h1) begin
                     n.st = RXS_STOP;
                  end
               end
            end
            RXS_STOP: begin
               if (r.sub == LAST_SUB) begin
                  n.valid = 1'b1;
                  n.ferr = ~r.s2;
                  n.st = RXS_IDLE;
               end
            end
            default: n.st = RXS_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         r <= '{s1: 1'b1, s2: 1'b1, st: RXS_IDLE, default: '0};
      end else if (i_ce) begin
         r <= n;
      end
   end

   assign o_valid = r.valid;
   assign o_data = r.sh;
   assign o_frame_err = r.ferr;
endmodule
`default_nettype wire

// *** mhsp_serial_port.sv ***
// host side serial port, transmit buffer, flow control and mode control of the modem
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - line idles high; start, 8 bits, stop
// - only eight payload bits go over radio
// - 7-bit parity formats pass as 8 bits
// - first host byte starts radio transmission
// - during reception host bytes wait in buffer
// - transmit buffer holds 132 bytes
// - clear-to-send goes high at 115 bytes
// - clear-to-send returns low below 98 bytes
// - host rate 2400 to 57600, obeys flow control
// - received bytes leave only after check passes
// - request-to-send level never gates output
// - command-select high routes characters to commands
// - forced entry low: command mode, default rate
// - forced entry changes no stored setting
// - idle unless busy; receive on radio data
// - idle to transmit on first buffered byte
// - transmit header, then packet with check
// - bytes kept until a packet carries them
// - defer transmission while others transmit
// - append 16-bit check; drop failed packets
// - packet carries bytes gathered, at most 64
// - bytes held in receive sent after idle
module mhsp_serial_port
   import mhsp_pkg::*;
(
   // clock, reset, enable
   input wire logic I_MCLK,
   input wire logic I_RST_B,
   input wire logic I_CE,
   // host pins
   input wire logic I_HOST_SERIAL_IN,
   output logic O_HOST_SERIAL_OUT,
   output logic O_CTS_N,
   input wire logic I_RTS_CMD,
   input wire logic I_FORCE_CMD_N,
   // stored configuration
   input wire logic [15:0] I_BAUD_DIV,
   // command characters and status
   output logic O_CMD_MODE,
   output logic O_CMD_VALID,
   output logic [7:0] O_CMD_DATA,
   output logic O_FRAME_ERR,
   output logic O_OVERRUN,
   output logic [7:0] O_BUF_LEVEL,
   output logic [1:0] O_MODE,
   // radio transmit stream
   output logic O_RF_TX_VALID,
   output logic [7:0] O_RF_TX_DATA,
   output logic [1:0] O_RF_TX_KIND,
   input wire logic I_RF_TX_READY,
   // radio receive stream
   input wire logic I_RF_DETECT,
   input wire logic I_RF_RX_VALID,
   input wire logic [7:0] I_RF_RX_DATA,
   input wire logic I_RF_RX_END
);
   typedef struct packed {
      mhsp_mode_t mode;
      logic cmd_s1;
      logic cmd_s2;
      logic frc_s1;
      logic frc_s2;
      logic cts_n;
      logic [7:0] count;
      logic [7:0] wr_ptr;
      logic [7:0] rd_ptr;
      logic [7:0] pkt_left;
      logic fetched;
      logic [15:0] crc;
      logic tx_full;
      logic [7:0] tx_data;
      logic [1:0] tx_kind;
      logic [6:0] rxw;
      logic [6:0] rxc;
      logic [6:0] rxr;
      logic [15:0] rx_crc;
      logic [6:0] rx_len;
      logic do_busy;
      logic do_fetched;
      logic [8:0] do_sh;
      logic [3:0] do_bit;
      logic [3:0] do_sub;
      logic [15:0] baud_cnt;
      logic do_line;
      logic cmd_valid;
      logic [7:0] cmd_data;
      logic ferr;
      logic ovr;
   } mhsp_state_t;

   mhsp_state_t r;
   mhsp_state_t n;

   logic cmd_mode;
   logic [15:0] div;
   logic rx_valid;
   logic [7:0] rx_data;
   logic rx_ferr;
   logic push;
   logic pop;
   logic [7:0] txq;
   logic [7:0] rxq;
   logic rxq_we;
   logic baud_tick;

   // ==========================================================
   // host receiver and the two byte stores
   // forced entry swaps in the default rate without touching the stored divisor
   assign div = r.frc_s2 ? I_BAUD_DIV : DEF_DIV;

   mhsp_uart_rx u_rx (
      .i_clk(I_MCLK),
      .i_rst_b(I_RST_B),
      .i_ce(I_CE),
      .i_line(I_HOST_SERIAL_IN),
      .i_div(div),
      .o_valid(rx_valid),
      .o_data(rx_data),
      .o_frame_err(rx_ferr)
   );

   mhsp_mem #(.DEPTH(int'(BUF_DEPTH)), .AW(8)) u_txmem (
      .i_clk(I_MCLK),
      .i_ce(I_CE),
      .i_we(push),
      .i_waddr(r.wr_ptr),
      .i_wdata(rx_data),
      .i_raddr(r.rd_ptr),
      .o_rdata(txq)
   );

   mhsp_mem #(.DEPTH(RXQ_DEPTH), .AW(7)) u_rxmem (
      .i_clk(I_MCLK),
      .i_ce(I_CE),
      .i_we(rxq_we),
      .i_waddr(r.rxw),
      .i_wdata(I_RF_RX_DATA),
      .i_raddr(r.rxr),
      .o_rdata(rxq)
   );

   // ==========================================================
   // next state
   always_comb begin
      n = r;
      n.cmd_valid = 1'b0;
      n.ferr = 1'b0;
      n.ovr = 1'b0;
      n.cmd_s1 = I_RTS_CMD;
      n.cmd_s2 = r.cmd_s1;
      n.frc_s1 = I_FORCE_CMD_N;
      n.frc_s2 = r.frc_s1;
      cmd_mode = r.cmd_s2 | ~r.frc_s2;
      pop = 1'b0;

      // host characters: commands, buffer, or dropped
      push = rx_valid & ~rx_ferr & ~cmd_mode & (r.count != BUF_DEPTH);
      n.ferr = rx_valid & rx_ferr;
      n.ovr = rx_valid & ~rx_ferr & ~cmd_mode & (r.count == BUF_DEPTH);
      if (rx_valid && !rx_ferr && cmd_mode) begin
         n.cmd_valid = 1'b1;
         n.cmd_data = rx_data;
      end
      if (push) begin
         n.wr_ptr = (r.wr_ptr == BUF_DEPTH - 8'h01) ? 8'h00 : r.wr_ptr + 8'h01;
      end

      // radio takes the presented byte; header acceptance fixes the packet size
      if (r.tx_full && I_RF_TX_READY) begin
         n.tx_full = 1'b0;
         if (r.tx_kind == KIND_HDR) begin
            n.pkt_left = (r.count > PKT_MAX) ? PKT_MAX : r.count;
         end
      end

      unique case (r.mode)
         MHSP_IDLE: begin
            if (I_RF_DETECT) begin
               n.mode = MHSP_RX;
            end else if (r.count != 8'h00) begin
               n.mode = MHSP_TX_HDR;
            end
         end
         MHSP_TX_HDR: begin
            if (!r.tx_full) begin
               n.tx_full = 1'b1;
               n.tx_data = HDR_TOKEN;
               n.tx_kind = KIND_HDR;
               n.crc = CRC_INIT;
               n.fetched = 1'b0;
               n.mode = MHSP_TX_DATA;
            end
         end
         MHSP_TX_DATA: begin
            // one idle cycle after each pop lets the registered read catch up
            if (!r.fetched) begin
               n.fetched = 1'b1;
            end else if (!r.tx_full) begin
               n.tx_full = 1'b1;
               n.tx_data = txq;
               n.tx_kind = KIND_DATA;
               n.crc = mhsp_crc16(r.crc, txq);
               n.fetched = 1'b0;
               pop = 1'b1;
               n.rd_ptr = (r.rd_ptr == BUF_DEPTH - 8'h01) ? 8'h00 : r.rd_ptr + 8'h01;
               n.pkt_left = r.pkt_left - 8'h01;
               if (r.pkt_left == 8'h01) begin
                  n.mode = MHSP_TX_CRC_HI;
               end
            end
         end
         MHSP_TX_CRC_HI: begin
            if (!r.tx_full) begin
               n.tx_full = 1'b1;
               n.tx_data = r.crc[15:8];
               n.tx_kind = KIND_CRC;
               n.mode = MHSP_TX_CRC_LO;
            end
         end
         MHSP_TX_CRC_LO: begin
            if (!r.tx_full) begin
               n.tx_full = 1'b1;
               n.tx_data = r.crc[7:0];
               n.tx_kind = KIND_CRC;
               n.mode = MHSP_TX_END;
            end
         end
         MHSP_TX_END: begin
            // a packet already begun is finished; the next one yields to the air
            if (!r.tx_full) begin
               if (I_RF_DETECT) begin
                  n.mode = MHSP_RX;
               end else if (r.count != 8'h00) begin
                  n.mode = MHSP_TX_HDR;
               end else begin
                  n.mode = MHSP_IDLE;
               end
            end
         end
         MHSP_RX: begin
            if (!I_RF_DETECT) begin
               n.mode = MHSP_IDLE;
            end
         end
      endcase

      // occupancy and flow control with hysteresis
      n.count = r.count + {7'h00, push} - {7'h00, pop};
      if (n.count >= CTS_OFF_LEVEL) begin
         n.cts_n = 1'b1;
      end else if (n.count < CTS_ON_LEVEL) begin
         n.cts_n = 1'b0;
      end

      // radio reception into the ring; only checked packets are committed
      rxq_we = I_RF_RX_VALID & (r.mode == MHSP_RX) & ((r.rxw + 7'h01) != r.rxr);
      if (rxq_we) begin
         n.rxw = r.rxw + 7'h01;
         n.rx_crc = mhsp_crc16(r.rx_crc, I_RF_RX_DATA);
         n.rx_len = (r.rx_len == 7'h7f) ? r.rx_len : r.rx_len + 7'h01;
      end
      if (I_RF_RX_END) begin
         // residue is zero when the trailing check bytes match
         if (r.rx_crc == 16'h0000 && r.rx_len > RX_CRC_LEN) begin
            n.rxw = r.rxw - RX_CRC_LEN;
            n.rxc = r.rxw - RX_CRC_LEN;
         end else begin
            n.rxw = r.rxc;
         end
         n.rx_crc = CRC_INIT;
         n.rx_len = 7'h00;
      end else if (r.mode == MHSP_RX && n.mode != MHSP_RX) begin
         n.rxw = r.rxc;   // truncated packet never passed its check
         n.rx_crc = CRC_INIT;
         n.rx_len = 7'h00;
      end

      // host serial output, bit timer free running at the receiver's rate, the default rate under forced entry
      baud_tick = (r.baud_cnt >= div - 16'h0001);
      n.baud_cnt = baud_tick ? 16'h0000 : r.baud_cnt + 16'h0001;
      if (!r.do_busy) begin
         // request-to-send is not consulted here
         if (r.rxr != r.rxc) begin
            if (!r.do_fetched) begin
               n.do_fetched = 1'b1;
            end else begin
               n.do_line = 1'b0;
               n.do_sh = {1'b1, rxq};
               n.do_busy = 1'b1;
               n.do_bit = 4'h0;
               n.do_sub = 4'h0;
               n.do_fetched = 1'b0;
               n.rxr = r.rxr + 7'h01;
            end
         end
      end else if (baud_tick) begin
         n.do_sub = r.do_sub + 4'h1;
         if (r.do_sub == LAST_SUB) begin
            if (r.do_bit == FRAME_LAST) begin
               n.do_busy = 1'b0;
            end else begin
               n.do_line = r.do_sh[0];
               n.do_sh = {1'b1, r.do_sh[8:1]};
               n.do_bit = r.do_bit + 4'h1;
            end
         end
      end
   end

   // ==========================================================
   // state register; enable low freezes everything
   always_ff @(posedge I_MCLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         r <= '{mode: MHSP_IDLE, cmd_s1: 1'b0, cmd_s2: 1'b0, frc_s1: 1'b1, frc_s2: 1'b1,
                crc: CRC_INIT, rx_crc: CRC_INIT, do_line: 1'b1, default: '0};
      end else if (I_CE) begin
         r <= n;
      end
   end

   // ==========================================================
   // outputs
   assign O_HOST_SERIAL_OUT = r.do_line;
   assign O_CTS_N = r.cts_n;
   assign O_CMD_MODE = r.cmd_s2 | ~r.frc_s2;
   assign O_CMD_VALID = r.cmd_valid;
   assign O_CMD_DATA = r.cmd_data;
   assign O_FRAME_ERR = r.ferr;
   assign O_OVERRUN = r.ovr;
   assign O_BUF_LEVEL = r.count;
   assign O_MODE = (r.mode == MHSP_IDLE) ? MODE_IDLE : ((r.mode == MHSP_RX) ? MODE_RX : MODE_TX);
   assign O_RF_TX_VALID = r.tx_full;
   assign O_RF_TX_DATA = r.tx_data;
   assign O_RF_TX_KIND = r.tx_kind;
endmodule
`default_nettype wire

// *** mhsp_chk_properties.sv ***
// pin-level assertions for the modem host serial port
`timescale 1ns/1ns
`default_nettype none
module mhsp_chk
   import mhsp_pkg::*;
(
   // clock and reset
   input wire logic I_MCLK,
   input wire logic I_RST_B,
   // host side
   input wire logic I_RTS_CMD,
   input wire logic I_FORCE_CMD_N,
   input wire logic O_CTS_N,
   input wire logic O_CMD_MODE,
   input wire logic O_OVERRUN,
   input wire logic [7:0] O_BUF_LEVEL,
   input wire logic [1:0] O_MODE,
   // radio side
   input wire logic I_RF_DETECT,
   input wire logic I_RF_TX_READY,
   input wire logic O_RF_TX_VALID,
   input wire logic [7:0] O_RF_TX_DATA,
   input wire logic [1:0] O_RF_TX_KIND
);
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (!I_RST_B);
   // ==========
   // packet steps
   sequence s_hdr_taken; O_RF_TX_VALID && I_RF_TX_READY && O_RF_TX_KIND == KIND_HDR; endsequence
   sequence s_data_shown; O_RF_TX_VALID && O_RF_TX_KIND == KIND_DATA; endsequence
   sequence s_hdr_shown; O_RF_TX_VALID && O_RF_TX_KIND == KIND_HDR; endsequence
   // ==========
   // flow control and buffer
   property p_cts_off; O_BUF_LEVEL >= CTS_OFF_LEVEL |-> O_CTS_N; endproperty
   a_cts_off: assert property (p_cts_off) else $error("cts low at high level");
   property p_cts_on; O_BUF_LEVEL < CTS_ON_LEVEL |-> !O_CTS_N; endproperty
   a_cts_on: assert property (p_cts_on) else $error("cts high at low level");
   // hysteresis: once off, stays off down to the lower level
   property p_cts_hold; $past(O_CTS_N) && O_BUF_LEVEL >= CTS_ON_LEVEL |-> O_CTS_N; endproperty
   a_cts_hold: assert property (p_cts_hold) else $error("cts released early");
   property p_lvl_max; O_BUF_LEVEL <= BUF_DEPTH; endproperty
   a_lvl_max: assert property (p_lvl_max) else $error("level above depth");
   // the drop pulse lags the full level by one edge; a pop may land in between
   property p_ovr_full; O_OVERRUN |-> $past(O_BUF_LEVEL) == BUF_DEPTH; endproperty
   a_ovr_full: assert property (p_ovr_full) else $error("drop while not full");
   // ==========
   // radio stream and modes
   property p_tx_hold; O_RF_TX_VALID && !I_RF_TX_READY |=> O_RF_TX_VALID && $stable(O_RF_TX_DATA)
      && $stable(O_RF_TX_KIND); endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("radio byte lost before taken");
   property p_rx_quiet; O_MODE == MODE_RX |-> !O_RF_TX_VALID; endproperty
   a_rx_quiet: assert property (p_rx_quiet) else $error("sending while receiving");
   property p_go_tx; O_MODE == MODE_IDLE && O_BUF_LEVEL != 8'h00 && !I_RF_DETECT |=> O_MODE == MODE_TX; endproperty
   a_go_tx: assert property (p_go_tx) else $error("no transmit on buffered byte");
   property p_hdr_first; $rose(O_MODE == MODE_TX) |-> ##[0:1] s_hdr_shown; endproperty
   a_hdr_first: assert property (p_hdr_first) else $error("header not first");
   property p_hdr_data; s_hdr_taken |-> ##[1:3] s_data_shown; endproperty
   a_hdr_data: assert property (p_hdr_data) else $error("no data after header");
   // ==========
   // command entry, after the two-flop synchronisers
   property p_cmd_force; !I_FORCE_CMD_N [*3] |-> O_CMD_MODE; endproperty
   a_cmd_force: assert property (p_cmd_force) else $error("forced entry ignored");
   property p_data_mode; (I_FORCE_CMD_N && !I_RTS_CMD) [*3] |-> !O_CMD_MODE; endproperty
   a_data_mode: assert property (p_data_mode) else $error("command mode without cause");
endmodule
bind mhsp_serial_port mhsp_chk chk_u (.*);
`default_nettype wire

// *** mhsp_host_model.sv ***
// host uart model: sends and receives 8-bit frames
`timescale 1ns/1ns
`default_nettype none
module mhsp_host_model #(
   parameter int DIV = 2
) (
   // clock
   input wire logic i_clk,
   // device pins
   input wire logic i_cts_n,
   input wire logic i_rx_line,
   output logic o_tx_line
);
   localparam int BITC = 16 * DIV;
   // line rests high between frames
   initial o_tx_line = 1'b1;
   // ==========
   // sender; trailing high bit also covers the two-stop-bit format
   task automatic send(input logic [7:0] b, input logic stop, input logic ign);
      logic [10:0] f;
      f = {1'b1, stop, b, 1'b0};
      while (i_cts_n && !ign) @(posedge i_clk);
      for (int i = 0; i < 11; i++) begin
         @(posedge i_clk);
         #1 o_tx_line = f[i];
         repeat (BITC - 1) @(posedge i_clk);
      end
      // hand back just after the edge, never inside it
      #1;
   endtask
   // ==========
   // receiver, mid-bit sampling; bounded wait for a start bit
   task automatic recv(output logic [7:0] b, output logic ok);
      int n;
      n = 0;
      b = 8'h00;
      while (i_rx_line !== 1'b0 && n < 4000) begin
         @(posedge i_clk);
         #1;
         n++;
      end
      ok = n < 4000;
      repeat (BITC / 2) @(posedge i_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BITC) @(posedge i_clk);
         #1 b[i] = i_rx_line;
      end
      repeat (BITC) @(posedge i_clk);
      #1 ok = ok && i_rx_line === 1'b1;
   endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench of the modem host serial port
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import mhsp_pkg::*;
   localparam int DIV = 2;
   logic clk = 1'b0, rst_b = 1'b0, rts = 1'b0, force_n = 1'b1, rdy = 1'b0, det = 1'b0;
   logic rxv = 1'b0, rxend = 1'b0, host_line, dout, cts_n, cmd_mode, cmd_v, fe, ovr, txv;
   logic [7:0] rxd = 8'h00, cmd_d, lvl, txd;
   logic [1:0] mode, kind;
   logic [9:0] txq[$], eq[$];
   int checked = 0, n_fail = 0, n_fe = 0, n_ov = 0, n_cmd = 0;
   always #5 clk = ~clk;
   mhsp_serial_port dut_u (.I_MCLK(clk), .I_RST_B(rst_b), .I_CE(1'b1), .I_HOST_SERIAL_IN(host_line),
      .O_HOST_SERIAL_OUT(dout), .O_CTS_N(cts_n), .I_RTS_CMD(rts), .I_FORCE_CMD_N(force_n),
      .I_BAUD_DIV(16'(DIV)), .O_CMD_MODE(cmd_mode), .O_CMD_VALID(cmd_v), .O_CMD_DATA(cmd_d),
      .O_FRAME_ERR(fe), .O_OVERRUN(ovr), .O_BUF_LEVEL(lvl), .O_MODE(mode), .O_RF_TX_VALID(txv),
      .O_RF_TX_DATA(txd), .O_RF_TX_KIND(kind), .I_RF_TX_READY(rdy), .I_RF_DETECT(det),
      .I_RF_RX_VALID(rxv), .I_RF_RX_DATA(rxd), .I_RF_RX_END(rxend));
   mhsp_host_model #(.DIV(DIV)) host_u (.i_clk(clk), .i_cts_n(cts_n), .i_rx_line(dout), .o_tx_line(host_line));
   // log taken radio bytes and pulses at the falling edge, clear of races
   always @(negedge clk) begin
      if (txv && rdy) txq.push_back({kind, txd});
      if (fe) n_fe++;
      if (ovr) n_ov++;
      if (cmd_v) n_cmd++;
   end
   // ==========
   // helpers
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // bit-serial form of the check, kept apart from the design's byte form
   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
      for (int i = 7; i >= 0; i--) c = (c[15] ^ d[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
      return c;
   endfunction
   task automatic add_pkt(input logic [7:0] d[$]);
      logic [15:0] c;
      c = CRC_INIT;
      eq.push_back({KIND_HDR, HDR_TOKEN});
      foreach (d[i]) begin
         eq.push_back({KIND_DATA, d[i]});
         c = crc_byte(c, d[i]);
      end
      eq.push_back({KIND_CRC, c[15:8]});
      eq.push_back({KIND_CRC, c[7:0]});
   endtask
   task automatic cmp_q();
      chk(txq.size(), eq.size());
      foreach (eq[i]) if (i < txq.size()) chk(txq[i], eq[i]);
      txq.delete();
      eq.delete();
   endtask
   // ==========
   // scenarios
   task automatic t_reset();
      chk({dout, cts_n, mode, lvl}, {1'b1, 1'b0, MODE_IDLE, 8'h00});
      $display("test reset done");
   endtask
   task automatic t_tx();
      rdy = 1'b1;
      host_u.send(8'h5a, 1'b1, 1'b0);
      host_u.send(8'h00, 1'b1, 1'b0);
      host_u.send(8'hff, 1'b1, 1'b0);
      step(60);
      add_pkt('{8'h5a});
      add_pkt('{8'h00});
      add_pkt('{8'hff});
      cmp_q();
      chk(mode, MODE_IDLE);
      $display("test transmit done");
   endtask
   task automatic t_defer();
      det = 1'b1;
      step(3);
      chk(mode, MODE_RX);
      host_u.send(8'ha5, 1'b1, 1'b0);
      host_u.send(8'h3c, 1'b1, 1'b0);
      chk({lvl, 8'(txq.size())}, {8'h02, 8'h00});
      det = 1'b0;
      step(60);
      add_pkt('{8'ha5, 8'h3c});
      cmp_q();
      $display("test defer done");
   endtask
   task automatic t_err_cmd();
      host_u.send(8'h77, 1'b0, 1'b0);
      step(4);
      chk(n_fe, 1);
      chk(txq.size(), 0);
      rts = 1'b1;
      host_u.send(8'h41, 1'b1, 1'b0);
      step(4);
      chk(n_cmd, 1);
      chk({8'(txq.size()), cmd_d, cmd_mode}, {8'h00, 8'h41, 1'b1});
      rts = 1'b0;
      force_n = 1'b0;
      step(3);
      chk(cmd_mode, 1'b1);
      force_n = 1'b1;
      step(3);
      $display("test error and command done");
   endtask
   task automatic t_rx(input logic [7:0] a, input logic [7:0] b, input logic bad);
      logic [15:0] c;
      logic [7:0] g;
      logic [7:0] p[4];
      logic ok;
      c = crc_byte(crc_byte(CRC_INIT, a), b);
      p = '{a, b, c[15:8], c[7:0] ^ {7'h00, bad}};
      det = 1'b1;
      rts = 1'b1;
      step(3);
      foreach (p[i]) begin
         rxv = 1'b1;
         rxd = p[i];
         step(1);
         rxv = 1'b0;
         step(1);
      end
      rxend = 1'b1;
      step(1);
      rxend = 1'b0;
      host_u.recv(g, ok);
      chk(ok, !bad);
      if (!bad) begin
         chk(g, a);
         host_u.recv(g, ok);
         chk({ok, g}, {1'b1, b});
      end
      det = 1'b0;
      rts = 1'b0;
      step(4);
      $display("test receive done");
   endtask
   task automatic t_fill();
      int k;
      logic [7:0] d[$];
      rdy = 1'b0;
      for (int i = 0; i < 133; i++) begin
         host_u.send(i[7:0], 1'b1, i >= 115);
         chk(cts_n, i >= 114);
      end
      chk(n_ov, 1);
      chk(lvl, BUF_DEPTH);
      rdy = 1'b1;
      k = 0;
      while (lvl !== 8'h00 && k < 3000) begin
         step(1);
         k++;
      end
      chk(lvl, 8'h00);
      step(20);
      chk(cts_n, 1'b0);
      for (int p = 0; p < 132; p += 64) begin
         d.delete();
         for (int i = p; i < p + 64 && i < 132; i++) d.push_back(i[7:0]);
         add_pkt(d);
      end
      cmp_q();
      $display("test fill done");
   endtask
   // ==========
   // verdict, shared with the watchdog
   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // run stays near 55k cycles; the limit leaves room to spare
   initial begin
      #900000;
      n_fail++;
      $display("watchdog expired at %0t", $time);
      tally_and_finish();
   end
   // main sequence
   initial begin
      step(4);
      rst_b = 1'b1;
      step(2);
      t_reset();
      t_tx();
      t_defer();
      t_err_cmd();
      t_rx(8'h12, 8'hc3, 1'b0);
      t_rx(8'h9e, 8'h01, 1'b1);
      t_fill();
      tally_and_finish();
   end
endmodule
`default_nettype wire
